// >>> rhtce_consts.svh
`ifndef RHTCE_CONSTS_SVH
`define RHTCE_CONSTS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define RHTCE_CLK_KHZ        40000
`define RHTCE_T_PU_US        300
`define RHTCE_T_SR_US        500
`define RHTCE_T_MEAS_L_US    1300
`define RHTCE_T_MEAS_M_US    3700
`define RHTCE_T_MEAS_H_US    6900
`define RHTCE_T_HEAT_L_MS    1000
`define RHTCE_T_HEAT_S_MS    100
`define RHTCE_US2CYC(t)      (((t) * `RHTCE_CLK_KHZ) / 1000)
`define RHTCE_MS2CYC(t)      ((t) * `RHTCE_CLK_KHZ)

// ----------------------------------------------------------------
// bus addresses and command codes
// ----------------------------------------------------------------
`define RHTCE_GC_ADDR        8'h00
`define RHTCE_GC_RESET       8'h06
`define RHTCE_CMD_MEAS_H     8'hfd
`define RHTCE_CMD_MEAS_M     8'hf6
`define RHTCE_CMD_MEAS_L     8'he0
`define RHTCE_CMD_SERIAL     8'h89
`define RHTCE_CMD_SOFTRST    8'h94
`define RHTCE_CMD_HEAT_LH    8'h39
`define RHTCE_CMD_HEAT_LM    8'h2f
`define RHTCE_CMD_HEAT_LL    8'h1e
`define RHTCE_CMD_HEAT_SH    8'h32
`define RHTCE_CMD_HEAT_SM    8'h24
`define RHTCE_CMD_HEAT_SL    8'h15

// ----------------------------------------------------------------
// checksum and response layout
// ----------------------------------------------------------------
`define RHTCE_CRC_POLY       8'h31
`define RHTCE_CRC_INIT       8'hff
`define RHTCE_CRC_XOROUT     8'h00
`define RHTCE_RESP_BYTES     3'h6
`define RHTCE_FILL_BYTE      8'hff

`endif

// >>> rhtce_pkg.sv
`include "rhtce_consts.svh"

package rhtce_pkg;

	typedef enum logic [2:0] {
		ST_BOOT  = 3'h0,
		ST_READY = 3'h1,
		ST_MEAS  = 3'h2,
		ST_HEAT  = 3'h3,
		ST_RST   = 3'h4
	} rhtce_state_e;

	typedef enum logic [2:0] {
		BT_IDLE  = 3'h0,
		BT_RX    = 3'h1,
		BT_RXACK = 3'h2,
		BT_TX    = 3'h3,
		BT_TXACK = 3'h4
	} rhtce_bit_e;

	function automatic logic [7:0] rhtce_crc8(input logic [15:0] d);
		logic [7:0] c;
		logic       fb;
		c = `RHTCE_CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c  = {c[6:0], 1'b0} ^ (fb ? `RHTCE_CRC_POLY : 8'h00);
		end
		return c ^ `RHTCE_CRC_XOROUT;
	endfunction : rhtce_crc8

endpackage : rhtce_pkg

// >>> rhtce_link_if.sv
`timescale 1ns/1ps

interface rhtce_link_if;
	logic       busy;
	logic [7:0] txData;
	logic [7:0] rxData;
	logic       rxValid;
	logic       rxGc;
	logic       rdStart;
	logic       txTake;

	modport target (input busy, input txData, output rxData, output rxValid, output rxGc,
		output rdStart, output txTake);
	modport engine (output busy, output txData, input rxData, input rxValid, input rxGc,
		input rdStart, input txTake);
endinterface : rhtce_link_if

// >>> rhtce_crc_unit.sv
`timescale 1ns/1ps

module rhtce_crc_unit (
	// clock
	input  wire logic        clk_sys,
	// data
	input  wire logic [15:0] word,
	output logic      [7:0]  crc
);
	logic [7:0] crc_r;
	logic [7:0] crc_nxt;

	always_comb begin
		crc_nxt = rhtce_pkg::rhtce_crc8(word);
	end

	always_ff @(posedge clk_sys) begin
		crc_r <= crc_nxt;
	end

	assign crc = crc_r;
endmodule : rhtce_crc_unit

// >>> rhtce_i2c_target.sv
`timescale 1ns/1ps
`include "rhtce_consts.svh"

module rhtce_i2c_target #(
	parameter logic [6:0] DEV_ADDR = 7'h40
) (
	// clock and reset
	input  wire logic    clk_sys,
	input  wire logic    reset,
	// bus pins
	input  wire logic    sclIn,
	input  wire logic    sdaIn,
	output logic         sdaOut,
	output logic         sdaOe,
	// engine side
	rhtce_link_if.target lnk
);
	logic sclS1_r, sclS2_r, sclD_r, sdaS1_r, sdaS2_r, sdaD_r;
	rhtce_pkg::rhtce_bit_e state_r, state_nxt;
	logic [3:0] bitCnt_r, bitCnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic       isAddr_r, isAddr_nxt, isRead_r, isRead_nxt, isGc_r, isGc_nxt;
	logic       sdaOe_r, sdaOe_nxt;
	logic [7:0] rxData_r, rxData_nxt;
	logic       rxValid_r, rxValid_nxt, rdStart_r, rdStart_nxt, txTake_r, txTake_nxt;
	logic       sclRise, sclFall, startCond, stopCond, match, ack;

	// ----------------------------------------------------------------
	// pin synchronisers, 40 MHz oversampling covers up to 1 MHz SCL
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sclS1_r <= 1'b1;
			sclS2_r <= 1'b1;
			sclD_r  <= 1'b1;
			sdaS1_r <= 1'b1;
			sdaS2_r <= 1'b1;
			sdaD_r  <= 1'b1;
		end else begin
			sclS1_r <= sclIn;
			sclS2_r <= sclS1_r;
			sclD_r  <= sclS2_r;
			sdaS1_r <= sdaIn;
			sdaS2_r <= sdaS1_r;
			sdaD_r  <= sdaS2_r;
		end
	end

	assign sclRise   = sclS2_r & ~sclD_r;
	assign sclFall   = ~sclS2_r & sclD_r;
	assign startCond = sclS2_r & sclD_r & sdaD_r & ~sdaS2_r;
	assign stopCond  = sclS2_r & sclD_r & ~sdaD_r & sdaS2_r;
	assign match     = (shift_r[7:1] == DEV_ADDR);

	// ----------------------------------------------------------------
	// bit engine
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt   = state_r;
		bitCnt_nxt  = bitCnt_r;
		shift_nxt   = shift_r;
		isAddr_nxt  = isAddr_r;
		isRead_nxt  = isRead_r;
		isGc_nxt    = isGc_r;
		sdaOe_nxt   = sdaOe_r;
		rxData_nxt  = rxData_r;
		rxValid_nxt = 1'b0;
		rdStart_nxt = 1'b0;
		txTake_nxt  = 1'b0;
		ack         = 1'b0;
		if (startCond) begin
			state_nxt  = rhtce_pkg::BT_RX;
			bitCnt_nxt = 4'h0;
			isAddr_nxt = 1'b1;
			isRead_nxt = 1'b0;
			isGc_nxt   = 1'b0;
			sdaOe_nxt  = 1'b0;
		end else if (stopCond) begin
			state_nxt = rhtce_pkg::BT_IDLE;
			sdaOe_nxt = 1'b0;
		end else begin
			case (state_r)
				rhtce_pkg::BT_RX: begin
					if (sclRise) begin
						shift_nxt  = {shift_r[6:0], sdaS2_r};
						bitCnt_nxt = bitCnt_r + 4'h1;
					end else if (sclFall && bitCnt_r == 4'h8) begin
						bitCnt_nxt = 4'h0;
						if (isAddr_r) begin
							// read header refused while busy
							ack         = (match && (!shift_r[0] || !lnk.busy)) || shift_r == `RHTCE_GC_ADDR;
							isRead_nxt  = match && shift_r[0];
							isGc_nxt    = !match;
							rdStart_nxt = ack && match && shift_r[0];
						end else begin
							ack         = 1'b1;
							rxValid_nxt = 1'b1;
							rxData_nxt  = shift_r;
						end
						sdaOe_nxt = ack;
						state_nxt = ack ? rhtce_pkg::BT_RXACK : rhtce_pkg::BT_IDLE;
					end
				end
				rhtce_pkg::BT_RXACK: begin
					if (sclFall) begin
						isAddr_nxt = 1'b0;
						if (isRead_r) begin
							shift_nxt  = lnk.txData;
							sdaOe_nxt  = !lnk.txData[7];
							txTake_nxt = 1'b1;
							bitCnt_nxt = 4'h1;
							state_nxt  = rhtce_pkg::BT_TX;
						end else begin
							sdaOe_nxt = 1'b0;
							state_nxt = rhtce_pkg::BT_RX;
						end
					end
				end
				rhtce_pkg::BT_TX: begin
					if (sclFall) begin
						if (bitCnt_r == 4'h8) begin
							sdaOe_nxt = 1'b0;
							state_nxt = rhtce_pkg::BT_TXACK;
						end else begin
							shift_nxt  = {shift_r[6:0], 1'b0};
							sdaOe_nxt  = !shift_r[6];
							bitCnt_nxt = bitCnt_r + 4'h1;
						end
					end
				end
				rhtce_pkg::BT_TXACK: begin
					// nack ends the read, even after a bare data word
					if (sclRise) begin
						state_nxt = sdaS2_r ? rhtce_pkg::BT_IDLE : rhtce_pkg::BT_RXACK;
					end
				end
				default: begin
					state_nxt = rhtce_pkg::BT_IDLE;
					sdaOe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r   <= rhtce_pkg::BT_IDLE;
			bitCnt_r  <= 4'h0;
			shift_r   <= 8'h00;
			isAddr_r  <= 1'b0;
			isRead_r  <= 1'b0;
			isGc_r    <= 1'b0;
			sdaOe_r   <= 1'b0;
			rxData_r  <= 8'h00;
			rxValid_r <= 1'b0;
			rdStart_r <= 1'b0;
			txTake_r  <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			bitCnt_r  <= bitCnt_nxt;
			shift_r   <= shift_nxt;
			isAddr_r  <= isAddr_nxt;
			isRead_r  <= isRead_nxt;
			isGc_r    <= isGc_nxt;
			sdaOe_r   <= sdaOe_nxt;
			rxData_r  <= rxData_nxt;
			rxValid_r <= rxValid_nxt;
			rdStart_r <= rdStart_nxt;
			txTake_r  <= txTake_nxt;
		end
	end

	assign sdaOut      = 1'b0;
	assign sdaOe       = sdaOe_r;
	assign lnk.rxData  = rxData_r;
	assign lnk.rxValid = rxValid_r;
	assign lnk.rxGc    = isGc_r;
	assign lnk.rdStart = rdStart_r;
	assign lnk.txTake  = txTake_r;
endmodule : rhtce_i2c_target

// >>> rhtce_engine.sv
// Function
// - after power-on reset, become idle and ready within 1 ms
// - soft reset 0x94 or general call reset: back to idle within 1 ms
// - conversions end within 1.6, 4.5 and 8.3 ms for low, medium, high
// - heater switches itself off after 1 s or 0.1 s pulse; here it stays on until the following measurement ends
// - answers are 16-bit words, high byte first, each followed by a checksum
// - 7-bit address plus direction bit; own address and general call write 0x00 answered
// - works at standard, fast and fast-plus bus speeds
// - read header refused while busy, accepted once results are ready
// - temperature word and checksum first, then humidity word and checksum
// - checksum is CRC-8, poly 0x31, init 0xff, no reflection, xor 0x00
// - controller may stop after a word without its checksum
// - 0xfd high, 0xf6 medium, 0xe0 low repeatability measurement, 6 bytes
// - long heater pulse: 0x39 high, 0x2f middle, 0x1e low power
// - short heater pulse: 0x32 high, 0x24 middle, 0x15 low power
// - heater command ends with high repeatability measurement, 6-byte answer
// - general call address 0x00 with byte 0x06 resets the device while idle
// - heater pulse always runs full time, then measurement, then off
`timescale 1ns/1ps
`include "rhtce_consts.svh"

module rhtce_engine #(
	parameter logic [6:0]  DEV_ADDR   = 7'h40,
	parameter logic [31:0] SERIAL_NUM = 32'h1234_5678, // arbitrary value
	parameter int          PU_CYC     = `RHTCE_US2CYC(`RHTCE_T_PU_US),
	parameter int          SR_CYC     = `RHTCE_US2CYC(`RHTCE_T_SR_US),
	parameter int          MEAS_L_CYC = `RHTCE_US2CYC(`RHTCE_T_MEAS_L_US),
	parameter int          MEAS_M_CYC = `RHTCE_US2CYC(`RHTCE_T_MEAS_M_US),
	parameter int          MEAS_H_CYC = `RHTCE_US2CYC(`RHTCE_T_MEAS_H_US),
	parameter int          HEAT_L_CYC = `RHTCE_MS2CYC(`RHTCE_T_HEAT_L_MS),
	parameter int          HEAT_S_CYC = `RHTCE_MS2CYC(`RHTCE_T_HEAT_S_MS)
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// bus pins
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	// sensor front end
	input  wire logic [15:0] tempSample,
	input  wire logic [15:0] humSample,
	output logic             measActive,
	output logic      [1:0]  measRep,
	output logic             heaterOn,
	output logic      [1:0]  heaterLevel,
	output logic             ready
);
	rhtce_link_if lnk ();

	rhtce_pkg::rhtce_state_e state_r, state_nxt;
	logic [26:0] cnt_r, cnt_nxt;
	logic [26:0] lim_r, lim_nxt;
	logic        measActive_r, measActive_nxt;
	logic [1:0]  measRep_r, measRep_nxt;
	logic        heaterOn_r, heaterOn_nxt;
	logic [1:0]  heaterLevel_r, heaterLevel_nxt;
	logic [15:0] word0_r, word0_nxt, word1_r, word1_nxt;
	logic        dataValid_r, dataValid_nxt;
	logic [2:0]  idx_r, idx_nxt;
	logic        ready_r, ready_nxt;
	logic [7:0]  crc0, crc1;
	logic [7:0]  txByte;
	logic        cmdIn, cmdKnown;

	// ----------------------------------------------------------------
	// bus target and checksum units
	// ----------------------------------------------------------------
	rhtce_i2c_target #(
		.DEV_ADDR (DEV_ADDR)
	) u_target (
		.clk_sys (clk_sys),
		.reset   (reset),
		.sclIn   (sclIn),
		.sdaIn   (sdaIn),
		.sdaOut  (sdaOut),
		.sdaOe   (sdaOe),
		.lnk     (lnk.target)
	);

	rhtce_crc_unit u_crc0 (
		.clk_sys (clk_sys),
		.word    (word0_r),
		.crc     (crc0)
	);

	rhtce_crc_unit u_crc1 (
		.clk_sys (clk_sys),
		.word    (word1_r),
		.crc     (crc1)
	);

	// ----------------------------------------------------------------
	// response byte select
	// ----------------------------------------------------------------
	always_comb begin
		txByte = `RHTCE_FILL_BYTE;
		if (dataValid_r) begin
			case (idx_r)
				3'h0: txByte = word0_r[15:8];
				3'h1: txByte = word0_r[7:0];
				3'h2: txByte = crc0;
				3'h3: txByte = word1_r[15:8];
				3'h4: txByte = word1_r[7:0];
				3'h5: txByte = crc1;
				default: txByte = `RHTCE_FILL_BYTE;
			endcase
		end
	end

	assign lnk.txData = txByte;
	assign lnk.busy   = (state_r != rhtce_pkg::ST_READY);

	// a command byte only counts from our own address while idle
	assign cmdIn    = lnk.rxValid && !lnk.rxGc && state_r == rhtce_pkg::ST_READY;
	assign cmdKnown = lnk.rxData inside {`RHTCE_CMD_MEAS_H, `RHTCE_CMD_MEAS_M, `RHTCE_CMD_MEAS_L,
		`RHTCE_CMD_SERIAL, `RHTCE_CMD_SOFTRST, `RHTCE_CMD_HEAT_LH, `RHTCE_CMD_HEAT_LM,
		`RHTCE_CMD_HEAT_LL, `RHTCE_CMD_HEAT_SH, `RHTCE_CMD_HEAT_SM, `RHTCE_CMD_HEAT_SL};

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt       = state_r;
		cnt_nxt         = cnt_r + 27'h1;
		lim_nxt         = lim_r;
		measActive_nxt  = measActive_r;
		measRep_nxt     = measRep_r;
		heaterOn_nxt    = heaterOn_r;
		heaterLevel_nxt = heaterLevel_r;
		word0_nxt       = word0_r;
		word1_nxt       = word1_r;
		dataValid_nxt   = dataValid_r;
		idx_nxt         = idx_r;
		if (lnk.rdStart) begin
			idx_nxt = 3'h0;
		end else if (lnk.txTake && idx_r != `RHTCE_RESP_BYTES) begin
			idx_nxt = idx_r + 3'h1;
		end
		case (state_r)
			rhtce_pkg::ST_BOOT, rhtce_pkg::ST_RST: begin
				if (cnt_r >= lim_r - 27'h1) begin
					state_nxt = rhtce_pkg::ST_READY;
				end
			end
			rhtce_pkg::ST_READY: begin
				cnt_nxt = 27'h0;
				if (lnk.rxValid && lnk.rxGc && lnk.rxData == `RHTCE_GC_RESET) begin
					state_nxt     = rhtce_pkg::ST_RST;
					lim_nxt       = 27'(SR_CYC);
					dataValid_nxt = 1'b0;
				end else if (cmdIn) begin
					case (lnk.rxData)
						`RHTCE_CMD_MEAS_H, `RHTCE_CMD_MEAS_M, `RHTCE_CMD_MEAS_L: begin
							state_nxt      = rhtce_pkg::ST_MEAS;
							measActive_nxt = 1'b1;
							dataValid_nxt  = 1'b0;
							if (lnk.rxData == `RHTCE_CMD_MEAS_H) begin
								lim_nxt     = 27'(MEAS_H_CYC);
								measRep_nxt = 2'h3;
							end else if (lnk.rxData == `RHTCE_CMD_MEAS_M) begin
								lim_nxt     = 27'(MEAS_M_CYC);
								measRep_nxt = 2'h2;
							end else begin
								lim_nxt     = 27'(MEAS_L_CYC);
								measRep_nxt = 2'h1;
							end
						end
						`RHTCE_CMD_SERIAL: begin
							word0_nxt     = SERIAL_NUM[31:16];
							word1_nxt     = SERIAL_NUM[15:0];
							dataValid_nxt = 1'b1;
						end
						`RHTCE_CMD_SOFTRST: begin
							state_nxt     = rhtce_pkg::ST_RST;
							lim_nxt       = 27'(SR_CYC);
							dataValid_nxt = 1'b0;
						end
						`RHTCE_CMD_HEAT_LH, `RHTCE_CMD_HEAT_LM, `RHTCE_CMD_HEAT_LL: begin
							state_nxt       = rhtce_pkg::ST_HEAT;
							lim_nxt         = 27'(HEAT_L_CYC);
							heaterOn_nxt    = 1'b1;
							dataValid_nxt   = 1'b0;
							heaterLevel_nxt = (lnk.rxData == `RHTCE_CMD_HEAT_LH) ? 2'h3 :
								(lnk.rxData == `RHTCE_CMD_HEAT_LM) ? 2'h2 : 2'h1;
						end
						`RHTCE_CMD_HEAT_SH, `RHTCE_CMD_HEAT_SM, `RHTCE_CMD_HEAT_SL: begin
							state_nxt       = rhtce_pkg::ST_HEAT;
							lim_nxt         = 27'(HEAT_S_CYC);
							heaterOn_nxt    = 1'b1;
							dataValid_nxt   = 1'b0;
							heaterLevel_nxt = (lnk.rxData == `RHTCE_CMD_HEAT_SH) ? 2'h3 :
								(lnk.rxData == `RHTCE_CMD_HEAT_SM) ? 2'h2 : 2'h1;
						end
						default: begin
							dataValid_nxt = 1'b0;
						end
					endcase
				end
			end
			rhtce_pkg::ST_HEAT: begin
				// no way out but the timer: the pulse always runs to the end
				if (cnt_r >= lim_r - 27'h1) begin
					state_nxt      = rhtce_pkg::ST_MEAS;
					cnt_nxt        = 27'h0;
					lim_nxt        = 27'(MEAS_H_CYC);
					measActive_nxt = 1'b1;
					measRep_nxt    = 2'h3;
				end
			end
			rhtce_pkg::ST_MEAS: begin
				if (cnt_r >= lim_r - 27'h1) begin
					state_nxt      = rhtce_pkg::ST_READY;
					measActive_nxt = 1'b0;
					heaterOn_nxt   = 1'b0;
					word0_nxt      = tempSample;
					word1_nxt      = humSample;
					dataValid_nxt  = 1'b1;
				end
			end
			default: begin
				state_nxt = rhtce_pkg::ST_RST;
				cnt_nxt   = 27'h0;
				lim_nxt   = 27'(SR_CYC);
			end
		endcase
		if (state_nxt == rhtce_pkg::ST_RST) begin
			measActive_nxt  = 1'b0;
			heaterOn_nxt    = 1'b0;
			heaterLevel_nxt = 2'h0;
		end
		ready_nxt = (state_nxt == rhtce_pkg::ST_READY);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r       <= rhtce_pkg::ST_BOOT;
			cnt_r         <= 27'h0;
			lim_r         <= 27'(PU_CYC);
			measActive_r  <= 1'b0;
			measRep_r     <= 2'h0;
			heaterOn_r    <= 1'b0;
			heaterLevel_r <= 2'h0;
			word0_r       <= 16'h0000;
			word1_r       <= 16'h0000;
			dataValid_r   <= 1'b0;
			idx_r         <= 3'h0;
			ready_r       <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			cnt_r         <= cnt_nxt;
			lim_r         <= lim_nxt;
			measActive_r  <= measActive_nxt;
			measRep_r     <= measRep_nxt;
			heaterOn_r    <= heaterOn_nxt;
			heaterLevel_r <= heaterLevel_nxt;
			word0_r       <= word0_nxt;
			word1_r       <= word1_nxt;
			dataValid_r   <= dataValid_nxt;
			idx_r         <= idx_nxt;
			ready_r       <= ready_nxt;
		end
	end

	assign measActive  = measActive_r;
	assign measRep     = measRep_r;
	assign heaterOn    = heaterOn_r;
	assign heaterLevel = heaterLevel_r;
	assign ready       = ready_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_boot_bound: assert property (@(posedge clk_sys) disable iff (reset)
		state_r == rhtce_pkg::ST_BOOT |-> cnt_r < 27'(PU_CYC))
		else $error("power-up wait overran");

	a_reset_bound: assert property (@(posedge clk_sys) disable iff (reset)
		state_r == rhtce_pkg::ST_RST |-> cnt_r < 27'(SR_CYC))
		else $error("reset recovery overran");

	a_meas_bound: assert property (@(posedge clk_sys) disable iff (reset)
		state_r == rhtce_pkg::ST_MEAS |-> measActive_r && cnt_r < lim_r && lim_r <= 27'(MEAS_H_CYC))
		else $error("measurement overran");

	a_heater_idle: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(heaterOn_r) |-> $past(state_r) == rhtce_pkg::ST_MEAS && ready_r && dataValid_r)
		else $error("heater stopped outside measurement end");

	a_crc_track: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(dataValid_r) |=> crc0 == rhtce_pkg::rhtce_crc8(word0_r) && crc1 == rhtce_pkg::rhtce_crc8(word1_r))
		else $error("checksum does not match word");

	a_busy_header: assert property (@(posedge clk_sys) disable iff (reset)
		lnk.rdStart |-> $past(state_r) == rhtce_pkg::ST_READY)
		else $error("read header accepted while busy");

	a_read_order: assert property (@(posedge clk_sys) disable iff (reset)
		lnk.rdStart |=> idx_r == 3'h0 && (!dataValid_r || txByte == word0_r[15:8]))
		else $error("read does not start with first word high byte");

	a_unknown_cmd: assert property (@(posedge clk_sys) disable iff (reset)
		cmdIn && !cmdKnown |=> state_r == rhtce_pkg::ST_READY && !dataValid_r && !heaterOn_r)
		else $error("unknown command changed state");

	a_heat_meas: assert property (@(posedge clk_sys) disable iff (reset)
		state_r == rhtce_pkg::ST_HEAT ##1 state_r == rhtce_pkg::ST_MEAS |-> heaterOn_r && measRep_r == 2'h3)
		else $error("heater measurement not high repeatability");
endmodule : rhtce_engine

// >>> rhtce_i2c_host.sv
`timescale 1ns/1ps

module rhtce_i2c_host (
	// bus pins
	output logic      scl,
	output logic      sdaLow,
	input  wire logic sda
);
	// scl rests high outside frames; sda released goes to the pull-up
	initial begin
		scl    = 1'b1;
		sdaLow = 1'b0;
	end

	task automatic start();
		sdaLow = 1'b1;
		#100;
		scl = 1'b0;
	endtask : start

	task automatic stop();
		#50;
		sdaLow = 1'b1;
		#50;
		scl = 1'b1;
		#100;
		sdaLow = 1'b0;
		#100;
	endtask : stop

	// data set mid low phase, sampled at the end of the high phase
	task automatic bit_io(input logic v, output logic r);
		#50;
		sdaLow = !v;
		#50;
		scl = 1'b1;
		#100;
		r = sda;
		scl = 1'b0;
	endtask : bit_io

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask : send_byte

	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask : recv_byte
endmodule : rhtce_i2c_host

// >>> testbench.sv
`timescale 1ns/1ps

module testbench;
	localparam logic [6:0] ADR = 7'h40;
	localparam logic [31:0] SN = 32'ha5c3_0f96; // arbitrary serial number
	localparam int PU = 150, SR = 150, ML = 100, MM = 140, MH = 180, HL = 600, HS = 300;
	logic        clk_sys, reset, sclLine, hostLow, sdaOut, sdaOe;
	logic        measActive, heaterOn, ready, a;
	logic [1:0]  measRep, heaterLevel;
	logic [15:0] tempSample, humSample, t, h;
	logic [7:0]  b;
	logic [7:0]  mc[3] = '{8'hfd, 8'hf6, 8'he0};
	logic [7:0]  hc[6] = '{8'h39, 8'h2f, 8'h1e, 8'h32, 8'h24, 8'h15};
	int          ml[3] = '{MH, MM, ML};
	int          err_count = 0;
	int          n_checks = 0;
	int          n;
	// wired-and with pull-up: either side may pull low
	wire         sdaBus = !((sdaOe && !sdaOut) || hostLow);

	rhtce_engine #(.DEV_ADDR(ADR), .SERIAL_NUM(SN), .PU_CYC(PU), .SR_CYC(SR), .MEAS_L_CYC(ML),
		.MEAS_M_CYC(MM), .MEAS_H_CYC(MH), .HEAT_L_CYC(HL), .HEAT_S_CYC(HS))
		i_dut (.clk_sys(clk_sys), .reset(reset),
		.sclIn(sclLine), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .tempSample(tempSample),
		.humSample(humSample), .measActive(measActive), .measRep(measRep), .heaterOn(heaterOn),
		.heaterLevel(heaterLevel), .ready(ready));
	rhtce_i2c_host i_host (.scl(sclLine), .sdaLow(hostLow), .sda(sdaBus));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [7:0] crc(input logic [15:0] d);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction : crc

	// bounded wait; running out counts as a mismatch
	task automatic wait_ready(input int lim);
		n = 0;
		while (ready !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= lim) begin
			check(n, 0);
			stop_test();
		end
	endtask : wait_ready

	task automatic hdr(input logic rd, output logic ak);
		i_host.start();
		i_host.send_byte({ADR, rd}, ak);
	endtask : hdr

	task automatic cmd(input logic [7:0] c);
		hdr(1'b0, a);
		check(a, 1);
		i_host.send_byte(c, a);
		check(a, 1);
		i_host.stop();
	endtask : cmd

	task automatic read6(input logic [47:0] e);
		hdr(1'b1, a);
		check(a, 1);
		for (int k = 0; k < 6; k++) begin
			i_host.recv_byte(k == 5, b);
			check(b, e[47 - 8 * k -: 8]);
		end
		i_host.stop();
	endtask : read6

	function automatic logic [47:0] resp(input logic [15:0] x, input logic [15:0] y);
		return {x, crc(x), y, crc(y)};
	endfunction : resp

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset      = 1'b1;
		tempSample = 16'h0000;
		humSample  = 16'h0000;
		void'($urandom(32'he426));
		repeat (3) @(posedge clk_sys);
		#1 reset = 1'b0;
		check(ready, 0);
		check(crc(16'hbeef), 8'h92);
		hdr(1'b1, a);
		check(a, 0);
		i_host.stop();
		wait_ready(PU);
		$display("test boot done");
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			#1;
			t          = $urandom;
			h          = $urandom;
			tempSample = t;
			humSample  = h;
			cmd(mc[i]);
			check(measActive, 1);
			check(measRep, 3 - i);
			hdr(1'b1, a);
			check(a, 0);
			i_host.stop();
			wait_ready(ml[i] + 10);
			read6(resp(t, h));
		end
		$display("test measure done");
		tempSample = 16'hffff;
		humSample  = 16'h0000;
		for (int i = 0; i < 6; i++) begin
			cmd(hc[i]);
			check(heaterOn, 1);
			check(heaterLevel, 3 - i % 3);
			wait_ready((i < 3 ? HL : HS) + MH + 20);
			check(n + 20 >= (i < 3 ? HL : HS), 1);
			check({heaterOn, measActive, measRep}, 4'h3);
			read6(resp(tempSample, humSample));
		end
		$display("test heater done");
		cmd(8'h89);
		hdr(1'b1, a);
		check(a, 1);
		i_host.recv_byte(1'b0, b);
		i_host.recv_byte(1'b1, b);
		i_host.stop();
		check(b, SN[23:16]);
		read6(resp(SN[31:16], SN[15:0]));
		$display("test serial done");
		cmd(8'h94);
		check(ready, 0);
		wait_ready(SR + 10);
		i_host.start();
		i_host.send_byte(8'h00, a);
		check(a, 1);
		i_host.send_byte(8'h06, a);
		check(a, 1);
		i_host.stop();
		check(ready, 0);
		wait_ready(SR + 10);
		$display("test reset done");
		// load valid data first so the unknown command has something to clear
		cmd(8'h89);
		cmd(8'h55);
		check(ready, 1);
		read6({6{8'hff}});
		hdr(1'b0, a);
		check(a, 1);
		i_host.stop();
		i_host.start();
		i_host.send_byte({ADR ^ 7'h01, 1'b0}, a);
		check(a, 0);
		i_host.stop();
		$display("test address done");
		stop_test();
	end
endmodule : testbench
